/* File: hw/adc_output_data_format.sv */
`timescale 1ns/1ps
module adc_output_data_format (
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  input  wire logic                             cfgWrite,
  input  wire logic [7:0]                       cfgAddr,
  input  wire logic [7:0]                       cfgWdata,
  output logic      [7:0]                       cfgRdata,
  input  wire logic                             convValid,
  input  wire logic                             convOverrange,
  input  wire logic [adc_fmt_pkg::SAMPLE_W-1:0] convSample,
  output logic                                  convReady,
  output adc_fmt_pkg::out_word_t                outWord,
  output logic                                  outValid,
  input  wire logic                             outReady
);
  import adc_fmt_pkg::*;

  localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;

  logic [7:0]          dataFormatCtrl;
  logic [2:0]          testPatternSelect;
  logic                altBitPolarityEn;
  logic                outputScrambleEn;
  logic                signedFormatSel;
  logic                phase;
  out_word_t           next_word;
  logic                fifoInReady;
  logic [WORD_W-1:0]   fifoData;
  logic                fifoValid;
  logic                fifoWrite;
  logic                fifoRead;
  logic                fifoPop;
  logic [LEVEL_W-1:0]  fifoLevel;
  logic [LEVEL_W-1:0]  next_level;

  assign testPatternSelect = dataFormatCtrl[PAT_LSB+2:PAT_LSB];
  assign altBitPolarityEn  = dataFormatCtrl[ALTPOL_BIT];
  assign outputScrambleEn  = dataFormatCtrl[SCRAMBLE_BIT];
  assign signedFormatSel   = dataFormatCtrl[SIGNED_BIT];

  // randomizer: bits 13..1 xor with bit 0, so bit 0 recovers the rest
  function automatic logic [SAMPLE_W-1:0] scramble(input logic [SAMPLE_W-1:0] w);
    scramble = w ^ {{(SAMPLE_W-1){w[0]}}, 1'b0};
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataFormatCtrl <= FMT_RESET;
    end else if (cfgWrite && cfgAddr == FMT_ADDR) begin
      dataFormatCtrl <= cfgWdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgRdata <= 8'h00;
    end else begin
      cfgRdata <= (cfgAddr == FMT_ADDR) ? dataFormatCtrl : 8'h00;
    end
  end

  always_comb begin
    logic [SAMPLE_W-1:0] s;
    s = convSample;
    if (signedFormatSel) begin
      s[SAMPLE_W-1] = ~s[SAMPLE_W-1];
    end
    if (outputScrambleEn) begin
      s = scramble(s);
    end
    if (altBitPolarityEn) begin
      s = s ^ ALTPOL_MASK;
    end
    next_word = '{overrangeFlag: convOverrange, sampleWord: s};
    unique case (testPatternSelect)
      PAT_OFF: next_word = next_word;
      PAT_ZERO: next_word = '0;
      PAT_ONE: next_word = '1;
      PAT_CHECKER: next_word = phase ? ~CHECKER_WORD : CHECKER_WORD;
      PAT_ALTERNATE: next_word = phase ? '1 : '0;
      default: next_word = next_word;
    endcase
  end

  // pattern phase advances once per accepted sample
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
    end else if (fifoWrite) begin
      phase <= ~phase;
    end
  end

  assign fifoWrite  = convValid && convReady;
  assign fifoPop    = outReady || !outValid;
  assign fifoRead   = fifoValid && fifoPop;
  assign next_level = LEVEL_W'(fifoLevel + fifoWrite - fifoRead);

  // ready is a flop fed by the predicted queue level, so it tracks the queue's own full flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fifoLevel <= '0;
      convReady <= 1'b0;
    end else begin
      fifoLevel <= next_level;
      convReady <= (next_level != LEVEL_W'(FIFO_DEPTH));
    end
  end

  sample_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inData   (next_word),
    .inValid  (fifoWrite),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outWord  <= '0;
      outValid <= 1'b0;
    end else if (fifoPop) begin
      outWord  <= fifoData;
      outValid <= fifoValid;
    end
  end

  // all-low pattern enters queue as zero
  pat_zero_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_ZERO |-> next_word == '0) else $error("all-low pattern wrong");

  pat_one_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_ONE |-> next_word == '1) else $error("all-high pattern wrong");

  checker_alt_a : assert property (@(posedge sys_clk) disable iff (rst)
    (testPatternSelect == PAT_CHECKER && fifoWrite) ##1 testPatternSelect == PAT_CHECKER
    |-> next_word == ~$past(next_word)) else $error("checkerboard did not alternate");

  checker_word_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_CHECKER |-> (next_word == CHECKER_WORD || next_word == ~CHECKER_WORD))
    else $error("checkerboard word wrong");

  alt_pattern_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_ALTERNATE |-> (next_word == '0 || next_word == '1))
    else $error("alternating pattern wrong");

  alt_toggle_a : assert property (@(posedge sys_clk) disable iff (rst)
    (testPatternSelect == PAT_ALTERNATE && fifoWrite) ##1 testPatternSelect == PAT_ALTERNATE
    |-> next_word == ~$past(next_word)) else $error("alternating pattern did not toggle");

  normal_pass_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_OFF && dataFormatCtrl[2:0] == 3'h0
    |-> next_word == {convOverrange, convSample}) else $error("normal data altered");

  // overflow flag passes in every format while testPatternSelect is PAT_OFF
  ovf_pass_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_OFF |-> next_word.overrangeFlag == convOverrange)
    else $error("overflow flag altered");

  alt_polarity_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_OFF && dataFormatCtrl[2:0] == 3'h4
    |-> next_word.sampleWord == (convSample ^ ALTPOL_MASK)) else $error("polarity mode wrong");

  scramble_on_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_OFF && dataFormatCtrl[2:0] == 3'h2
    |-> next_word.sampleWord[0] == convSample[0]
    && (next_word.sampleWord[SAMPLE_W-1:1] ^ convSample[SAMPLE_W-1:1]) == {(SAMPLE_W-1){convSample[0]}})
    else $error("randomizer wrong");

  signed_fmt_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_OFF && dataFormatCtrl[2:0] == 3'h1
    |-> next_word.sampleWord == {~convSample[SAMPLE_W-1], convSample[SAMPLE_W-2:0]}) else $error("format bit wrong");

  pattern_raw_a : assert property (@(posedge sys_clk) disable iff (rst)
    testPatternSelect == PAT_ONE && dataFormatCtrl[2:0] != 3'h0 |-> next_word == '1)
    else $error("pattern was processed");

  // registered ready never offers space the queue lacks
  ready_match_a : assert property (@(posedge sys_clk) disable iff (rst)
    convReady |-> fifoInReady) else $error("ready ahead of queue");

  // predicted level stays within depth
  level_bound_a : assert property (@(posedge sys_clk) disable iff (rst)
    fifoLevel <= LEVEL_W'(FIFO_DEPTH)) else $error("queue level above depth");

  // a stalled output word stands until taken
  out_hold_a : assert property (@(posedge sys_clk) disable iff (rst)
    outValid && !outReady |=> outValid && $stable(outWord)) else $error("stalled word changed");

  // pattern phase steps once per accepted sample
  phase_step_a : assert property (@(posedge sys_clk) disable iff (rst)
    fifoWrite |=> phase != $past(phase)) else $error("phase did not step");
  phase_hold_a : assert property (@(posedge sys_clk) disable iff (rst)
    !fifoWrite |=> $stable(phase)) else $error("phase moved without sample");

  // writes elsewhere leave the format register alone
  other_addr_a : assert property (@(posedge sys_clk) disable iff (rst)
    !(cfgWrite && cfgAddr == FMT_ADDR) |=> $stable(dataFormatCtrl)) else $error("format register changed");
endmodule

/* File: hw/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= AW'(wrPtr + 1'b1);
      end
      if (doRead) begin
        rdPtr <= AW'(rdPtr + 1'b1);
      end
      count <= (AW+1)'(count + doWrite - doRead);
    end
  end

  fifo_bound_a : assert property (@(posedge sys_clk) disable iff (rst) count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

/* File: include/adc_fmt_pkg.sv */
package adc_fmt_pkg;
  localparam int          SAMPLE_W      = 14;
  localparam int          WORD_W        = 15;
  localparam int          FIFO_DEPTH    = 8;
  localparam logic [7:0]  FMT_ADDR      = 8'h04;
  localparam logic [7:0]  FMT_RESET     = 8'h00;
  localparam int          SIGNED_BIT    = 0;
  localparam int          SCRAMBLE_BIT  = 1;
  localparam int          ALTPOL_BIT    = 2;
  localparam int          PAT_LSB       = 3;
  localparam logic [2:0]  PAT_OFF       = 3'h0;
  localparam logic [2:0]  PAT_ZERO      = 3'h1;
  localparam logic [2:0]  PAT_ONE       = 3'h3;
  localparam logic [2:0]  PAT_CHECKER   = 3'h5;
  localparam logic [2:0]  PAT_ALTERNATE = 3'h7;
  localparam logic [14:0] CHECKER_WORD  = 15'h5555;
  localparam logic [13:0] ALTPOL_MASK   = 14'h2aaa;

  typedef struct packed {
    logic                overrangeFlag;
    logic [SAMPLE_W-1:0] sampleWord;
  } out_word_t;
endpackage

/* File: tb/adc_output_data_format_bench.sv */
`timescale 1ns/1ps
module adc_output_data_format_bench;
  import adc_fmt_pkg::*;
  logic sys_clk, rst, cfgWrite, convValid, convOverrange, convReady, outValid, outReady, holdOff, streamOn;
  logic holdBroken;
  logic [7:0] cfgAddr, cfgWdata, cfgRdata, fmt;
  logic [13:0] convSample;
  out_word_t outWord;
  int err_count = 0, num_checks = 0, taken = 0, lastTaken = 0, base;
  logic [14:0] expQ[$];
  logic [2:0] pats[5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};

  adc_output_data_format adc_output_data_format_inst (.sys_clk(sys_clk), .rst(rst), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .convValid(convValid),
    .convOverrange(convOverrange), .convSample(convSample), .convReady(convReady), .outWord(outWord),
    .outValid(outValid), .outReady(outReady));
  capture_sink capture_sink_inst (.sys_clk(sys_clk), .rst(rst), .outWord(outWord), .outValid(outValid),
    .holdOff(holdOff), .outReady(outReady), .holdBroken(holdBroken));

  function automatic logic [14:0] expect_word(logic [7:0] f, logic ovf, logic [13:0] s, int ph);
    logic [13:0] d;
    d = s;
    case (f[5:3])
      3'h1: return 15'h0000;
      3'h3: return 15'h7fff;
      3'h5: return (ph % 2) ? 15'h2aaa : 15'h5555;
      3'h7: return (ph % 2) ? 15'h7fff : 15'h0000;
      default: begin
        if (f[0]) d[13] = ~d[13];
        if (f[1]) d[13:1] = d[13:1] ^ {13{d[0]}};
        if (f[2]) d = d ^ 14'h2aaa;
        return {ovf, d};
      end
    endcase
  endfunction

  task automatic check(string name, logic [14:0] seen, logic [14:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rw(logic we, logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    cfgAddr = a;
    cfgWdata = d;
    cfgWrite = we;
    @(negedge sys_clk);
    cfgWrite = 1'b0;
    if (we && a == 8'h04) fmt = d;
    @(negedge sys_clk);
    check("cfgRdata", {7'h0, cfgRdata}, (a == 8'h04) ? {7'h0, fmt} : 15'h0);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((expQ.size() != 0 || convValid) && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 2000) check("drain", 15'h1, 15'h0);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (!rst && convValid && convReady) begin
      expQ.push_back(expect_word(fmt, convOverrange, convSample, taken));
      taken++;
    end
    if (!rst && outValid && outReady) begin
      if (expQ.size() == 0) check("outValid", 15'h1, 15'h0);
      else check("outWord", outWord, expQ.pop_front());
    end
  end

  // sample held until accepted
  always @(negedge sys_clk) begin
    if (!convValid || taken != lastTaken) begin
      convValid = streamOn && ($urandom % 4 != 0);
      convSample = 14'($urandom);
      convOverrange = 1'($urandom);
    end
    lastTaken = taken;
  end

  initial begin
    #200_000;
    err_count++;
    final_report();
  end

  initial begin
    {rst, cfgWrite, cfgAddr, cfgWdata, convValid, convOverrange, convSample} = '0;
    rst = 1'b1;
    {holdOff, streamOn} = 2'b00;
    fmt = 8'h00;
    void'($urandom(60));
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    rw(1'b0, 8'h04, 8'h00);
    rw(1'b1, 8'h05, 8'hff);
    rw(1'b0, 8'h04, 8'h00);
    for (int i = 0; i < 40; i++) begin
      rw(1'b1, 8'h04, {2'b00, pats[i % 5], 3'(i / 5)});
      streamOn = 1'b1;
      repeat (40) @(negedge sys_clk);
      streamOn = 1'b0;
      drain();
    end
    holdOff = 1'b1;
    @(negedge sys_clk);
    base = taken;
    streamOn = 1'b1;
    repeat (40) @(negedge sys_clk);
    check("fillCount", 15'(taken - base), 15'h9);
    check("convReady", {14'h0, convReady}, 15'h0);
    streamOn = 1'b0;
    holdOff = 1'b0;
    drain();
    check("holdBroken", {14'h0, holdBroken}, 15'h0);
    final_report();
  end
endmodule

/* File: tb/capture_sink.sv */
`timescale 1ns/1ps
module capture_sink (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire adc_fmt_pkg::out_word_t outWord,
  input  wire logic                   outValid,
  input  wire logic                   holdOff,
  output logic                        outReady,
  output logic                        holdBroken
);
  import adc_fmt_pkg::*;
  logic      wasStalled;
  out_word_t heldWord;
  initial begin
    outReady = 1'b0;
    holdBroken = 1'b0;
    wasStalled = 1'b0;
    heldWord = '0;
  end
  // stalls at random, or hard while holdOff
  always @(negedge sys_clk) outReady <= !rst && !holdOff && ($urandom % 4 != 0);
  // a word left waiting must still stand, unchanged, at the next edge
  always @(posedge sys_clk) begin
    if (!rst && wasStalled && (!outValid || outWord !== heldWord)) holdBroken <= 1'b1;
    wasStalled <= !rst && outValid && !outReady;
    heldWord <= outWord;
  end
endmodule
